// ### core/vdmwt_ctrl.sv
// Controller that drives a dual-port video DRAM through its strobes on orders from an Avalon-MM slave.
//
// Functional notes
// - Load-mask: write timing, select high at row fall, low at column fall.
// - Block write: select high at column fall; column mask taken at later strobe.
// - The controller refuses any block write until a load-color cycle has set the color loaded flag.
// - Load-color: select high at row and column falls; single byte strobe loads one byte.
`timescale 1ns/1ns
module vdmwt_ctrl (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // Avalon-MM slave.
    input  wire logic [2:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Memory pins.
    output logic             row_strobe_n_o,
    output logic             low_byte_column_strobe_n_o,
    output logic             high_byte_column_strobe_n_o,
    output logic             write_strobe_n_o,
    output logic             transfer_gate_n_o,
    output logic             special_function_select_o,
    output logic      [8:0]  mem_addr_o,
    input  wire logic [15:0] random_io_pins_i,
    output logic      [15:0] random_io_pins_o,
    output logic             random_io_pins_oe_o,
    output logic             busy_o
);

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_SETUP = 7'h02,
        ST_RAS   = 7'h04,
        ST_COL   = 7'h08,
        ST_CAS   = 7'h10,
        ST_HOLD  = 7'h20,
        ST_PRE   = 7'h40
    } vdmwt_state_t;

    // Levels of transfer gate, write strobe and select at the row strobe fall.
    function automatic vdmwt_pkg::vdmwt_ras_lvl_t ras_levels(input logic [3:0] op);
        vdmwt_pkg::vdmwt_ras_lvl_t lvl;
        lvl = '{trg_n: 1'b1, we_n: 1'b1, special_function_select: 1'b0};
        case (op)
            vdmwt_pkg::OP_MASKED_WRITE,
            vdmwt_pkg::OP_MASKED_BLOCK:   lvl.we_n = 1'b0;
            vdmwt_pkg::OP_LOAD_MASK:      lvl.special_function_select = 1'b1;
            vdmwt_pkg::OP_LOAD_COLOR:     lvl.special_function_select = 1'b1;
            vdmwt_pkg::OP_ROW_TRANSFER:   lvl.trg_n = 1'b0;
            vdmwt_pkg::OP_HALF_TRANSFER: begin
                lvl.trg_n = 1'b0;
                lvl.special_function_select   = 1'b1;
            end
            vdmwt_pkg::OP_REFRESH_KEEP:   lvl.special_function_select = 1'b1;
            default:                      lvl.special_function_select = 1'b0;
        endcase
        return lvl;
    endfunction : ras_levels

    // Select level at the first column strobe fall.
    function automatic logic cas_dsf(input logic [3:0] op);
        return (op == vdmwt_pkg::OP_MASKED_BLOCK) || (op == vdmwt_pkg::OP_UNMASKED_BLOCK) ||
               (op == vdmwt_pkg::OP_LOAD_COLOR);
    endfunction : cas_dsf

    function automatic logic is_block(input logic [3:0] op);
        return (op == vdmwt_pkg::OP_MASKED_BLOCK) || (op == vdmwt_pkg::OP_UNMASKED_BLOCK);
    endfunction : is_block

    function automatic logic is_transfer(input logic [3:0] op);
        return (op == vdmwt_pkg::OP_ROW_TRANSFER) || (op == vdmwt_pkg::OP_HALF_TRANSFER);
    endfunction : is_transfer

    function automatic logic is_refresh(input logic [3:0] op);
        return (op == vdmwt_pkg::OP_REFRESH_CLEAR) || (op == vdmwt_pkg::OP_REFRESH_KEEP);
    endfunction : is_refresh

    function automatic logic is_known(input logic [3:0] op);
        return op <= vdmwt_pkg::OP_REFRESH_KEEP;
    endfunction : is_known

    vdmwt_state_t           state;
    vdmwt_pkg::vdmwt_cmd_t  cmd;
    vdmwt_pkg::vdmwt_pins_t pins;
    logic [8:0]             row_addr;
    logic [8:0]             col_addr;
    logic [15:0]            ras_dq;
    logic [15:0]            cas_dq;
    logic [15:0]            dq_sample;
    logic                   persist_mode;
    logic                   color_loaded;
    logic                   refused;
    logic                   busy;
    logic                   bus_req;
    logic                   bus_take;
    logic                   cmd_write;
    logic                   cmd_ok;
    logic                   cmd_accept;
    logic                   cmd_refuse;
    logic                   tmr_done;
    logic                   advance;
    logic                   tmr_start;
    logic [7:0]             tmr_len;
    vdmwt_pkg::vdmwt_cmd_t  new_cmd;
    logic [31:0]            next_readdata;
    vdmwt_pkg::vdmwt_ras_lvl_t ras_lvl;

    // Bus decode. A command word is only answered once the memory cycle in flight is over.
    assign bus_req    = avs_read_i | avs_write_i;
    assign cmd_write  = avs_write_i && (avs_address_i == vdmwt_pkg::REG_CMD);
    assign bus_take   = bus_req && !avs_waitrequest_o;
    assign new_cmd    = '{op: avs_writedata_i[vdmwt_pkg::CMD_OP_LSB +: 4],
                          hi_en: avs_writedata_i[vdmwt_pkg::CMD_HI_BIT],
                          lo_en: avs_writedata_i[vdmwt_pkg::CMD_LO_BIT]};
    assign ras_lvl    = ras_levels(new_cmd.op);
    assign cmd_ok     = is_known(new_cmd.op) && !(is_block(new_cmd.op) && !color_loaded) &&
                        (is_transfer(new_cmd.op) || is_refresh(new_cmd.op) || new_cmd.lo_en || new_cmd.hi_en);
    assign cmd_accept = bus_take && cmd_write && cmd_ok;
    assign cmd_refuse = bus_take && cmd_write && !cmd_ok;

    // Waitrequest rises again after every answer; a command waits while the pins are busy.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if (bus_take) begin
            avs_waitrequest_o <= 1'b1;
        end else if (bus_req && !(cmd_write && busy)) begin
            avs_waitrequest_o <= 1'b0;
        end
    end

    // Read data mux, registered so that it stands at the edge where waitrequest is low.
    always_comb begin
        next_readdata = vdmwt_pkg::WORD_RST;
        case (avs_address_i)
            vdmwt_pkg::REG_CMD:    next_readdata[5:0] = cmd;
            vdmwt_pkg::REG_ROW:    next_readdata[8:0] = row_addr;
            vdmwt_pkg::REG_COL:    next_readdata[8:0] = col_addr;
            vdmwt_pkg::REG_RASDQ:  next_readdata[15:0] = ras_dq;
            vdmwt_pkg::REG_CASDQ:  next_readdata[15:0] = cas_dq;
            vdmwt_pkg::REG_STATUS: begin
                next_readdata[vdmwt_pkg::ST_BUSY_BIT]  = busy;
                next_readdata[vdmwt_pkg::ST_PERS_BIT]  = persist_mode;
                next_readdata[vdmwt_pkg::ST_COLOR_BIT] = color_loaded;
                next_readdata[vdmwt_pkg::ST_REFU_BIT]  = refused;
            end
            vdmwt_pkg::REG_SAMPLE: next_readdata[15:0] = dq_sample;
            default:               next_readdata = vdmwt_pkg::WORD_RST;
        endcase
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= vdmwt_pkg::WORD_RST;
        end else if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= next_readdata;
        end
    end

    // Address and data registers written by software.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            row_addr <= vdmwt_pkg::ADDR_RST;
            col_addr <= vdmwt_pkg::ADDR_RST;
            ras_dq   <= vdmwt_pkg::DQ_RST;
            cas_dq   <= vdmwt_pkg::DQ_RST;
        end else if (bus_take && avs_write_i) begin
            case (avs_address_i)
                vdmwt_pkg::REG_ROW:   row_addr <= avs_writedata_i[8:0];
                vdmwt_pkg::REG_COL:   col_addr <= avs_writedata_i[8:0];
                vdmwt_pkg::REG_RASDQ: ras_dq   <= avs_writedata_i[15:0];
                vdmwt_pkg::REG_CASDQ: cas_dq   <= avs_writedata_i[15:0];
                default:              row_addr <= row_addr;
            endcase
        end
    end

    // Command latch; only accepted commands replace it.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd <= '0;
        end else if (cmd_accept) begin
            cmd <= new_cmd;
        end
    end

    // Refused flag: hardware set wins over a software clear in the same cycle.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            refused <= 1'b0;
        end else if (cmd_refuse) begin
            refused <= 1'b1;
        end else if (bus_take && avs_write_i && (avs_address_i == vdmwt_pkg::REG_STATUS) &&
                     avs_writedata_i[vdmwt_pkg::ST_REFU_BIT]) begin
            refused <= 1'b0;
        end
    end

    // Phase timer: restarted on every state change.
    assign advance   = (state != ST_IDLE) && tmr_done;
    assign tmr_start = cmd_accept || advance;
    assign tmr_len   = (state == ST_HOLD) ? vdmwt_pkg::PRE_CYC : vdmwt_pkg::PHASE_CYC;

    vdmwt_phase_timer u_timer (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (tmr_start),
        .len_i     (tmr_len),
        .done_o    (tmr_done)
    );

    // Strobe sequencer. Refresh skips the column phases because its column strobes fall first.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
            pins  <= vdmwt_pkg::PINS_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cmd_accept) begin
                        state          <= ST_SETUP;
                        pins.addr      <= row_addr;
                        pins.trg_n     <= ras_lvl.trg_n;
                        pins.we_n      <= ras_lvl.we_n;
                        pins.special_function_select       <= ras_lvl.special_function_select;
                        pins.dq        <= ras_dq;
                        pins.dq_oe     <= !is_transfer(new_cmd.op) && !is_refresh(new_cmd.op);
                        if (is_refresh(new_cmd.op)) begin
                            pins.cas_l_n <= 1'b0;
                            pins.cas_u_n <= 1'b0;
                        end
                    end
                end
                ST_SETUP: begin
                    if (advance) begin
                        state      <= ST_RAS;
                        pins.ras_n <= 1'b0;
                    end
                end
                ST_RAS: begin
                    if (advance) begin
                        state <= is_refresh(cmd.op) ? ST_HOLD : ST_COL;
                        // Column bit 8 picks the half.
                        // Low column bits give the tap.
                        pins.addr <= is_block(cmd.op) ? (col_addr & vdmwt_pkg::BLOCK_COL_MASK) : col_addr;
                        pins.special_function_select  <= cas_dsf(cmd.op);
                        if (!is_transfer(cmd.op) && !is_refresh(cmd.op)) begin
                            // Column mask on pins, color internal.
                            pins.we_n  <= 1'b0;
                            pins.dq    <= cas_dq;
                            pins.dq_oe <= 1'b1;
                        end else begin
                            pins.dq_oe <= 1'b0;
                        end
                    end
                end
                ST_COL: begin
                    if (advance) begin
                        state <= ST_CAS;
                        if (is_transfer(cmd.op)) begin
                            pins.cas_l_n <= 1'b0;
                            pins.cas_u_n <= 1'b0;
                        end else begin
                            // Single byte strobe loads one byte.
                            pins.cas_l_n <= !cmd.lo_en;
                            pins.cas_u_n <= !cmd.hi_en;
                        end
                    end
                end
                ST_CAS: begin
                    if (advance) begin
                        state      <= ST_HOLD;
                        // Gate trailing edge moves the half row.
                        pins.trg_n <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    if (advance) begin
                        state <= ST_PRE;
                        pins  <= vdmwt_pkg::PINS_IDLE;
                    end
                end
                ST_PRE: begin
                    if (advance) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    pins  <= vdmwt_pkg::PINS_IDLE;
                end
            endcase
        end
    end

    // Pins sampled at the end of the hold phase, for software to inspect.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dq_sample <= vdmwt_pkg::DQ_RST;
        end else if ((state == ST_HOLD) && advance) begin
            dq_sample <= random_io_pins_i;
        end
    end

    // Shadow of the device's masking mode, updated as the row strobe falls.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            persist_mode <= 1'b0;
        end else if ((state == ST_SETUP) && advance) begin
            if (cmd.op == vdmwt_pkg::OP_LOAD_MASK) begin
                persist_mode <= 1'b1;
            end else if (cmd.op == vdmwt_pkg::OP_REFRESH_CLEAR) begin
                persist_mode <= 1'b0;
            end
        end
    end

    // Color loaded flag; the device keeps the color until power loss, so only reset clears it.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            color_loaded <= 1'b0;
        end else if ((state == ST_CAS) && advance && (cmd.op == vdmwt_pkg::OP_LOAD_COLOR)) begin
            color_loaded <= 1'b1;
        end
    end

    // Busy stands from acceptance until the precharge phase ends.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy <= 1'b0;
        end else if (cmd_accept) begin
            busy <= 1'b1;
        end else if ((state == ST_PRE) && advance) begin
            busy <= 1'b0;
        end
    end

    assign busy_o                      = busy;
    assign row_strobe_n_o              = pins.ras_n;
    assign low_byte_column_strobe_n_o  = pins.cas_l_n;
    assign high_byte_column_strobe_n_o = pins.cas_u_n;
    assign write_strobe_n_o            = pins.we_n;
    assign transfer_gate_n_o           = pins.trg_n;
    assign special_function_select_o   = pins.special_function_select;
    assign mem_addr_o                  = pins.addr;
    assign random_io_pins_o            = pins.dq;
    assign random_io_pins_oe_o         = pins.dq_oe;

endmodule : vdmwt_ctrl

// ### core/vdmwt_pkg.sv
// Package with register map, pin bundle, operation codes and timing for the video DRAM controller.
package vdmwt_pkg;

    // Register word indices; byte address is four times the index.
    localparam logic [2:0] REG_CMD    = 3'h0;
    localparam logic [2:0] REG_ROW    = 3'h1;
    localparam logic [2:0] REG_COL    = 3'h2;
    localparam logic [2:0] REG_RASDQ  = 3'h3;
    localparam logic [2:0] REG_CASDQ  = 3'h4;
    localparam logic [2:0] REG_STATUS = 3'h5;
    localparam logic [2:0] REG_SAMPLE = 3'h6;

    // Field positions inside the command and status words.
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_LO_BIT   = 4;
    localparam int CMD_HI_BIT   = 5;
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_PERS_BIT  = 1;
    localparam int ST_COLOR_BIT = 2;
    localparam int ST_REFU_BIT  = 3;

    localparam int ADDR_W = 9;
    localparam int DQ_W   = 16;

    // Reset values.
    localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
    localparam logic [DQ_W-1:0]   DQ_RST   = 16'h0000;
    localparam logic [31:0]       WORD_RST = 32'h0000_0000;

    // Block writes ignore the two lowest column bits.
    localparam logic [ADDR_W-1:0] BLOCK_COL_MASK = 9'h1FC;

    // Timing: clock period and the length of each strobe phase, in ns.
    localparam int CLK_NS   = 100;
    localparam int PHASE_NS = 100;
    localparam int PRE_NS   = 200;
    localparam int PHASE_CYC_I = (PHASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PRE_CYC_I   = (PRE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] PHASE_CYC = 8'(PHASE_CYC_I < 1 ? 1 : PHASE_CYC_I);
    localparam logic [7:0] PRE_CYC   = 8'(PRE_CYC_I < 1 ? 1 : PRE_CYC_I);

    // Operations that software may start.
    typedef enum logic [3:0] {
        OP_MASKED_WRITE     = 4'h0,
        OP_UNMASKED_WRITE   = 4'h1,
        OP_MASKED_BLOCK     = 4'h2,
        OP_UNMASKED_BLOCK   = 4'h3,
        OP_LOAD_MASK        = 4'h4,
        OP_LOAD_COLOR       = 4'h5,
        OP_ROW_TRANSFER     = 4'h6,
        OP_HALF_TRANSFER    = 4'h7,
        OP_REFRESH_CLEAR    = 4'h8,
        OP_REFRESH_KEEP     = 4'h9
    } vdmwt_op_t;

    // Command as held by the controller.
    typedef struct packed {
        logic [3:0] op;
        logic       hi_en;
        logic       lo_en;
    } vdmwt_cmd_t;

    // Levels sampled by the device at the row strobe fall.
    typedef struct packed {
        logic trg_n;
        logic we_n;
        logic special_function_select;
    } vdmwt_ras_lvl_t;

    // Everything the controller drives toward the memory.
    typedef struct packed {
        logic              ras_n;
        logic              cas_l_n;
        logic              cas_u_n;
        logic              we_n;
        logic              trg_n;
        logic              special_function_select;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0]   dq;
        logic              dq_oe;
    } vdmwt_pins_t;

    localparam vdmwt_pins_t PINS_IDLE = '{ras_n: 1'b1, cas_l_n: 1'b1, cas_u_n: 1'b1, we_n: 1'b1,
                                          trg_n: 1'b1, special_function_select: 1'b0, addr: ADDR_RST, dq: DQ_RST,
                                          dq_oe: 1'b0};

endpackage : vdmwt_pkg

// ### core/vdmwt_phase_timer.sv
// Down-counter that measures the length of one strobe phase.
`timescale 1ns/1ns
module vdmwt_phase_timer (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       start_i,
    input  wire logic [7:0] len_i,
    output logic            done_o
);

    logic [7:0] cnt;

    // Reload on start, then count down to zero and rest there.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 8'h00;
        end else if (start_i) begin
            cnt <= len_i;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end

    // The phase ends in the cycle in which one count is left.
    assign done_o = (cnt == 8'h01);

endmodule : vdmwt_phase_timer

// ### tb/vdmwt_ctrl_assertions.sv
// Checker for strobe order and bus handshake of the video DRAM controller.
`timescale 1ns/1ns
module vdmwt_ctrl_assertions (
    input wire logic       mclk_i,
    input wire logic       sys_rst_i,
    input wire logic [2:0] avs_address_i,
    input wire logic       avs_write_i,
    input wire logic       avs_waitrequest_o,
    input wire logic       row_strobe_n_o,
    input wire logic       low_byte_column_strobe_n_o,
    input wire logic       high_byte_column_strobe_n_o,
    input wire logic       write_strobe_n_o,
    input wire logic       transfer_gate_n_o,
    input wire logic       special_function_select_o,
    input wire logic [8:0] mem_addr_o,
    input wire logic       random_io_pins_oe_o,
    input wire logic       busy_o
);
    // Active-high views; either byte strobe low counts as the column strobe.
    wire row_on = !row_strobe_n_o;
    wire col_on = !(low_byte_column_strobe_n_o && high_byte_column_strobe_n_o);
    wire we_on  = !write_strobe_n_o;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // Row fall of a write cycle, then a column fall with the select high.
    sequence blk_s;
        $rose(row_on) && !special_function_select_o && transfer_gate_n_o ##2 $rose(col_on) && special_function_select_o;
    endsequence
    AST_BLOCK_ADDR: assert property (blk_s |-> mem_addr_o[1:0] == 2'h0)
        else $error("block address low bits set");
    AST_MASK_AT_ROW: assert property ($rose(row_on) && we_on |-> random_io_pins_oe_o)
        else $error("mask not driven at row fall");
    AST_DATA_AT_COL: assert property ($rose(col_on) && we_on |-> random_io_pins_oe_o)
        else $error("data not driven at column fall");
    AST_XFER_FORM: assert property ($rose(row_on) && !transfer_gate_n_o |-> !we_on ##1 !random_io_pins_oe_o)
        else $error("transfer form wrong");
    AST_REFRESH_FORM: assert property ($rose(row_on) && col_on |-> !we_on && transfer_gate_n_o)
        else $error("refresh form wrong");
    AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    AST_HOLD_BUSY: assert property (avs_write_i && avs_address_i == vdmwt_pkg::REG_CMD && busy_o |=> avs_waitrequest_o)
        else $error("command taken while busy");
    AST_BUSY_SPAN: assert property ($rose(busy_o) |-> busy_o[*5] ##[1:3] !busy_o)
        else $error("memory cycle length wrong");
endmodule : vdmwt_ctrl_assertions
bind vdmwt_ctrl vdmwt_ctrl_assertions chk_u (.*);

// ### tb/vdmwt_dram_model.sv
// Behavioural model of the DRAM's mask, color and persistent-mode state.
`timescale 1ns/1ns
module vdmwt_dram_model (
    input  wire logic        row_n_i,
    input  wire logic        col_lo_n_i,
    input  wire logic        col_hi_n_i,
    input  wire logic        we_n_i,
    input  wire logic        gate_n_i,
    input  wire logic        sel_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        oe_i,
    output logic      [15:0] dq_o
);
    logic [15:0] mask;
    logic [15:0] color;
    logic        pers = 1'b0;
    logic        ldreg;
    wire col_n = col_lo_n_i & col_hi_n_i;
    // Released pins show the inverted color, so a stale drive never passes as data.
    assign dq_o = oe_i ? dq_i : ~color;
    // Row fall decode; keep-options refresh leaves pers alone.
    always @(negedge row_n_i) begin
        ldreg = col_n & gate_n_i & we_n_i & sel_i;
        if (col_n & gate_n_i & !we_n_i & !pers) mask = dq_i;
        if (!col_n & !sel_i) pers = 1'b0;
    end
    // Column fall is the later edge here, loading bytes per strobe.
    always @(negedge col_n) begin
        if (!row_n_i && ldreg) begin
            if (sel_i) color = {col_hi_n_i ? color[15:8] : dq_i[15:8], col_lo_n_i ? color[7:0] : dq_i[7:0]};
            if (!sel_i) mask = {col_hi_n_i ? mask[15:8] : dq_i[15:8], col_lo_n_i ? mask[7:0] : dq_i[7:0]};
            pers = pers | !sel_i;
        end
    end
endmodule : vdmwt_dram_model

// ### tb/test_video_dram_masked_write_and_transfer.sv
// Self-checking bench: Avalon accesses drive the controller against the DRAM model.
`timescale 1ns/1ns
module test_video_dram_masked_write_and_transfer;
    logic        mclk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [2:0]  adr = 3'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        wreq, rn, cln, chn, wn, gn, sel, oe, busy;
    logic [8:0]  madr;
    logic [15:0] pin_in, pin_out;
    int          err_total = 0;
    int          n_tests = 0;
    vdmwt_ctrl dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .row_strobe_n_o(rn), .low_byte_column_strobe_n_o(cln), .high_byte_column_strobe_n_o(chn),
        .write_strobe_n_o(wn), .transfer_gate_n_o(gn), .special_function_select_o(sel), .mem_addr_o(madr),
        .random_io_pins_i(pin_in), .random_io_pins_o(pin_out), .random_io_pins_oe_o(oe), .busy_o(busy));
    vdmwt_dram_model mem_u (.row_n_i(rn), .col_lo_n_i(cln), .col_hi_n_i(chn), .we_n_i(wn), .gate_n_i(gn),
        .sel_i(sel), .dq_i(pin_out), .oe_i(oe), .dq_o(pin_in));
    // Free-running 100 ns clock.
    always #50 mclk_i = ~mclk_i;
    // Compare one value and count it.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask : chk
    // One Avalon access held until waitrequest is low; a read compares with d.
    task automatic acc(input logic w, input logic [2:0] a, input logic [31:0] d, input string msg);
        @(posedge mclk_i);
        wr <= w;
        rd <= !w;
        adr <= a;
        wdat <= d;
        do @(posedge mclk_i); while (wreq !== 1'b0);
        wr <= 1'b0;
        rd <= 1'b0;
        if (!w) chk(rdat, d, msg);
    endtask : acc
    // Start a memory cycle, then let its seven cycles (five for a refresh) run out.
    task automatic cmd(input vdmwt_pkg::vdmwt_op_t op, input logic [1:0] en);
        acc(1'b1, vdmwt_pkg::REG_CMD, {26'h0, en, op}, "");
        repeat (8) @(posedge mclk_i);
    endtask : cmd
    // Print the counts and the verdict, then stop.
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    // Main sequence.
    initial begin
        repeat (3) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        acc(1'b0, vdmwt_pkg::REG_STATUS, 32'h0, "status at reset");
        acc(1'b0, 3'h7, 32'h0, "unmapped read");
        acc(1'b1, vdmwt_pkg::REG_ROW, 32'h1FF, "");
        acc(1'b0, vdmwt_pkg::REG_ROW, 32'h1FF, "row register");
        $display("test registers done");
        cmd(vdmwt_pkg::OP_MASKED_BLOCK, 2'h3);
        acc(1'b0, vdmwt_pkg::REG_STATUS, 32'h8, "block before color");
        acc(1'b1, vdmwt_pkg::REG_STATUS, 32'h8, "");
        acc(1'b1, vdmwt_pkg::REG_CASDQ, 32'hA5C3, "");
        // The transfer after this load-color is held by waitrequest while the color cycle runs.
        acc(1'b1, vdmwt_pkg::REG_CMD, 32'h35, "");
        cmd(vdmwt_pkg::OP_ROW_TRANSFER, 2'h3);
        acc(1'b0, vdmwt_pkg::REG_SAMPLE, 32'h5A3C, "color both bytes");
        acc(1'b1, vdmwt_pkg::REG_CASDQ, 32'h0011, "");
        cmd(vdmwt_pkg::OP_LOAD_COLOR, 2'h1);
        cmd(vdmwt_pkg::OP_HALF_TRANSFER, 2'h3);
        acc(1'b0, vdmwt_pkg::REG_SAMPLE, 32'h5AEE, "color low byte");
        $display("test color done");
        // Low column bits set, so the checker sees whether block cycles drop them.
        acc(1'b1, vdmwt_pkg::REG_COL, 32'h107, "");
        cmd(vdmwt_pkg::OP_MASKED_BLOCK, 2'h3);
        cmd(vdmwt_pkg::OP_UNMASKED_BLOCK, 2'h3);
        cmd(vdmwt_pkg::OP_UNMASKED_WRITE, 2'h2);
        cmd(vdmwt_pkg::OP_LOAD_MASK, 2'h3);
        chk(mem_u.mask, 32'h0011, "mask loaded");
        acc(1'b0, vdmwt_pkg::REG_STATUS, 32'h6, "persistent set");
        cmd(vdmwt_pkg::OP_REFRESH_KEEP, 2'h3);
        cmd(vdmwt_pkg::OP_MASKED_WRITE, 2'h3);
        chk(mem_u.mask, 32'h0011, "mask kept");
        acc(1'b0, vdmwt_pkg::REG_STATUS, 32'h6, "persistent kept");
        cmd(vdmwt_pkg::OP_REFRESH_CLEAR, 2'h3);
        chk(mem_u.pers, 32'h0, "device mode cleared");
        acc(1'b0, vdmwt_pkg::REG_STATUS, 32'h4, "persistent cleared");
        acc(1'b1, vdmwt_pkg::REG_RASDQ, 32'h00F0, "");
        cmd(vdmwt_pkg::OP_MASKED_WRITE, 2'h1);
        chk(mem_u.mask, 32'h00F0, "mask at row fall");
        // An unknown operation and a write with no byte enabled are both refused.
        acc(1'b1, vdmwt_pkg::REG_CMD, 32'h3A, "");
        acc(1'b0, vdmwt_pkg::REG_STATUS, 32'hC, "unknown op refused");
        acc(1'b1, vdmwt_pkg::REG_STATUS, 32'h8, "");
        acc(1'b1, vdmwt_pkg::REG_CMD, 32'h0, "");
        acc(1'b0, vdmwt_pkg::REG_STATUS, 32'hC, "no byte refused");
        $display("test mode done");
        final_report();
    end
    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        repeat (3000) @(posedge mclk_i);
        err_total++;
        final_report();
    end
endmodule : test_video_dram_masked_write_and_transfer
